// ### lusim_params.svh
// Constants for the line unit system interface mux
`ifndef LUSIM_PARAMS_SVH
`define LUSIM_PARAMS_SVH
`define LUSIM_NCH          8
`define LUSIM_SR1_HOLD     16
`define LUSIM_CNT_W        5
`define LUSIM_MCLK_CLK_NS  10
`define LUSIM_MCLK_STATIC  8
`endif

// ### lusim_pkg.sv
// Types for the line unit system interface mux
`default_nettype none
package lusim_pkg;
  typedef enum logic [3:0] {
    LUSIM_DR_CR   = 4'h1,
    LUSIM_DR_RAW  = 4'h2,
    LUSIM_SR1     = 4'h4,
    LUSIM_SR2     = 4'h8
  } lusim_mode_e;
  typedef enum logic [1:0] {
    LUSIM_MCLK_RUN  = 2'h0,
    LUSIM_MCLK_HIGH = 2'h1,
    LUSIM_MCLK_LOW  = 2'h2
  } lusim_mclk_e;
  typedef struct packed {
    logic pos;
    logic neg;
  } lusim_rail_s;
  typedef logic [7:0] lusim_ch_t;
endpackage : lusim_pkg
`default_nettype wire

// ### lusim_top.sv
// Per-channel system interface selection and edge control, eight channels
// Contract
// R1: One global T1/E1 mode: pins in hardware mode, register in software mode.
// R2: Each channel supports single rail, dual rail recovered, dual rail raw.
// R3: Eight identical channels, indexed 0 to 7.
// R4: Dual rail passes tx rails to line, rx rails and recovered clock out.
// R5: After reset each channel is dual rail with clock recovery.
// R6: Raw mode outputs unretimed slicer rails, their XOR on receive clock.
// R7: Single rail uses AMI or substitution codec, flags code violations.
// R8: Negative tx rail high over 16 clocks selects single rail sub-mode 1.
// R9: Host single-rail bit 1, bypass bit 0 selects single rail sub-mode 2.
// R10: Sub-mode 2 with AMI inserts bipolar violation from negative rail pin.
// R11: Host bypass bit 1, single-rail bit 0 selects raw dual rail.
// R12: Both host bits 0 with running master clock gives recovered dual rail.
// R13: Master clock static high makes receivers slice only.
// R14: Master clock static low powers receivers down.
// R15: Edge select high: receive on rising, serial out on falling; low reversed.
// R16: Receive, violation and serial outputs active high on the selected edge.
// R17: In raw mode edge select sets slicer output polarity.
// R18: Serial host input sampled on rising serial clock edges always.
// R19: Transmit inputs sampled on falling transmit clock edges always.
// R20: Master clock held high ignores bypass bits, forces raw dual rail.
// R21: Dual rail modes bypass codec and ignore line-code selections.
// R22: Held-high detector restarts on any low sample, leaving sub-mode 1.
`default_nettype none
`include "lusim_params.svh"
module lusim_top (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                tx_line_clock,
  input  wire logic                host_mode,
  input  wire logic [2:0]          template_select_pins,
  input  wire logic [2:0]          template_select_reg,
  input  wire logic                mclk_in,
  input  wire logic                edge_polarity_select,
  input  wire lusim_pkg::lusim_ch_t recovery_bypass_reg,
  input  wire lusim_pkg::lusim_ch_t single_rail_reg,
  input  wire lusim_pkg::lusim_ch_t line_code_ami,
  input  wire lusim_pkg::lusim_ch_t tx_pos_rail,
  input  wire lusim_pkg::lusim_ch_t tx_neg_rail,
  input  wire lusim_pkg::lusim_ch_t rx_slice_pos,
  input  wire lusim_pkg::lusim_ch_t rx_slice_neg,
  input  wire lusim_pkg::lusim_ch_t rx_dec_data,
  input  wire lusim_pkg::lusim_ch_t rx_dec_viol,
  input  wire lusim_pkg::lusim_ch_t rx_rec_pos,
  input  wire lusim_pkg::lusim_ch_t rx_rec_neg,
  input  wire lusim_pkg::lusim_ch_t rx_rec_clk,
  output logic [2:0]               template_select,
  output lusim_pkg::lusim_ch_t     rx_pos_rail,
  output lusim_pkg::lusim_ch_t     rx_neg_rail,
  output lusim_pkg::lusim_ch_t     rx_recovered_clock,
  output lusim_pkg::lusim_ch_t     line_tx_pos,
  output lusim_pkg::lusim_ch_t     line_tx_neg,
  output lusim_pkg::lusim_ch_t     codec_enable,
  output lusim_pkg::lusim_ch_t     bipolar_violation_insert,
  output lusim_pkg::lusim_ch_t     receiver_power_down,
  output logic [31:0]              channel_mode
);
  import lusim_pkg::*;

  // Master clock state: edges detected in clk; static after LUSIM_MCLK_STATIC idle cycles
  logic       mclk_s1_ff;
  logic       mclk_s2_ff;
  logic       mclk_d_ff;
  logic [3:0] mclk_idle_ff;
  logic [3:0] nxt_mclk_idle;
  lusim_mclk_e mclk_st_ff;
  lusim_mclk_e nxt_mclk_st;
  logic [2:0] ts_ff;
  logic       edge_s1_ff;
  logic       edge_s2_ff;
  logic       host_s1_ff;
  logic       host_s2_ff;
  wire        mclk_edge = mclk_s2_ff ^ mclk_d_ff;
  wire        mclk_idle_done = (mclk_idle_ff == 4'(`LUSIM_MCLK_STATIC));

  assign nxt_mclk_idle = mclk_edge ? 4'h0 : (mclk_idle_done ? mclk_idle_ff : mclk_idle_ff + 4'h1);
  assign nxt_mclk_st   = !mclk_idle_done ? LUSIM_MCLK_RUN :
                         (mclk_d_ff ? LUSIM_MCLK_HIGH : LUSIM_MCLK_LOW);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mclk_s1_ff   <= 1'b0;
      mclk_s2_ff   <= 1'b0;
      mclk_d_ff    <= 1'b0;
      mclk_idle_ff <= 4'h0;
      mclk_st_ff   <= LUSIM_MCLK_RUN;
      edge_s1_ff   <= 1'b0;
      edge_s2_ff   <= 1'b0;
      host_s1_ff   <= 1'b0;
      host_s2_ff   <= 1'b0;
      ts_ff        <= 3'h0;
    end else begin
      mclk_s1_ff   <= mclk_in;
      mclk_s2_ff   <= mclk_s1_ff;
      mclk_d_ff    <= mclk_s2_ff;
      mclk_idle_ff <= nxt_mclk_idle;
      mclk_st_ff   <= nxt_mclk_st;
      edge_s1_ff   <= edge_polarity_select;
      edge_s2_ff   <= edge_s1_ff;
      host_s1_ff   <= host_mode;
      host_s2_ff   <= host_s1_ff;
      ts_ff        <= host_s2_ff ? template_select_reg : template_select_pins; // R1
    end
  end
  assign template_select = ts_ff;

  // Per-channel status levels carried to the link domain through two flops
  logic [7:0] lk_host_s1_ff, lk_host_s2_ff;
  logic [7:0] lk_mhi_s1_ff, lk_mhi_s2_ff;
  logic [7:0] lk_mlo_s1_ff, lk_mlo_s2_ff;
  logic [7:0] lk_edge_s1_ff, lk_edge_s2_ff;

  genvar g;
  generate
    for (g = 0; g < `LUSIM_NCH; g++) begin : g_ch // R3
      logic                   nrail_low_ff;
      logic [`LUSIM_CNT_W-1:0] hold_cnt_ff;
      logic [`LUSIM_CNT_W-1:0] nxt_hold_cnt;
      logic                   tx_pos_ff;
      logic                   tx_neg_ff;
      lusim_mode_e            mode_ff;
      lusim_mode_e            nxt_mode;
      logic                   rxp_ff, rxn_ff, rxc_ff;
      logic                   rx_pn_rise_ff, rx_nn_rise_ff;
      logic                   rx_pn_fall_ff, rx_nn_fall_ff;
      lusim_rail_s            rx_rec;
      wire sr1_hit = (hold_cnt_ff > 5'(`LUSIM_SR1_HOLD));
      wire l_host  = lk_host_s2_ff[g];
      wire l_mhi   = lk_mhi_s2_ff[g];
      wire l_mlo   = lk_mlo_s2_ff[g];
      wire l_edge  = lk_edge_s2_ff[g];
      wire tx_dual = (mode_ff == LUSIM_DR_CR) || (mode_ff == LUSIM_DR_RAW);

      // Count saturates just past the threshold; any low sample restarts it
      assign nxt_hold_cnt = !tx_neg_rail[g] ? '0 :
                            (sr1_hit ? hold_cnt_ff : hold_cnt_ff + 5'h1); // R22

      // Mode priority: static high clock forces raw, then held-high rail, then host bits
      always_comb begin
        nxt_mode = LUSIM_DR_CR; // R5 R12
        if (l_mhi)
          nxt_mode = LUSIM_DR_RAW; // R13 R20
        else if (sr1_hit && tx_neg_rail[g])
          nxt_mode = LUSIM_SR1; // R8 R22
        else if (l_host && single_rail_reg[g] && !recovery_bypass_reg[g])
          nxt_mode = LUSIM_SR2; // R9
        else if (l_host && recovery_bypass_reg[g] && !single_rail_reg[g])
          nxt_mode = LUSIM_DR_RAW; // R11
      end

      // Transmit side sampled on falling link clock edge
      always_ff @(negedge tx_line_clock or negedge rstn) begin
        if (!rstn) begin
          hold_cnt_ff <= '0;
          tx_pos_ff   <= 1'b0;
          tx_neg_ff   <= 1'b0;
          mode_ff     <= LUSIM_DR_CR;
        end else begin
          hold_cnt_ff <= nxt_hold_cnt;
          tx_pos_ff   <= tx_pos_rail[g]; // R19
          tx_neg_ff   <= tx_neg_rail[g]; // R19
          mode_ff     <= nxt_mode; // R2
        end
      end

      assign rx_rec.pos = tx_dual ? rx_rec_pos[g] : rx_dec_data[g];
      assign rx_rec.neg = tx_dual ? rx_rec_neg[g] : rx_dec_viol[g]; // R7

      // Recovered-clock outputs launched on both edges, chosen by edge select
      always_ff @(posedge rx_rec_clk[g] or negedge rstn) begin
        if (!rstn) begin
          rx_pn_rise_ff <= 1'b0;
          rx_nn_rise_ff <= 1'b0;
        end else begin
          rx_pn_rise_ff <= rx_rec.pos; // R15 R16
          rx_nn_rise_ff <= rx_rec.neg;
        end
      end
      always_ff @(negedge rx_rec_clk[g] or negedge rstn) begin
        if (!rstn) begin
          rx_pn_fall_ff <= 1'b0;
          rx_nn_fall_ff <= 1'b0;
        end else begin
          rx_pn_fall_ff <= rx_rec.pos; // R15 R16
          rx_nn_fall_ff <= rx_rec.neg;
        end
      end

      // Raw slicing is unretimed, so the outputs follow the slicer directly
      wire raw  = (mode_ff == LUSIM_DR_RAW);
      wire slp  = l_edge ? rx_slice_pos[g] : !rx_slice_pos[g]; // R17
      wire sln  = l_edge ? rx_slice_neg[g] : !rx_slice_neg[g]; // R17
      wire rcp  = l_edge ? rx_pn_rise_ff : rx_pn_fall_ff;
      wire rcn  = l_edge ? rx_nn_rise_ff : rx_nn_fall_ff;
      assign rx_pos_rail[g]        = l_mlo ? 1'b0 : (raw ? slp : rcp); // R4 R6 R14
      assign rx_neg_rail[g]        = l_mlo ? 1'b0 : (raw ? sln : rcn); // R4 R6
      assign rx_recovered_clock[g] = l_mlo ? 1'b0 :
                                     (raw ? (rx_slice_pos[g] ^ rx_slice_neg[g]) : rx_rec_clk[g]); // R6
      assign line_tx_pos[g]        = tx_pos_ff; // R4
      assign line_tx_neg[g]        = tx_dual ? tx_neg_ff : 1'b0; // R4
      assign codec_enable[g]       = !tx_dual; // R21 R7
      assign bipolar_violation_insert[g] =
        (mode_ff == LUSIM_SR2) && line_code_ami[g] && tx_neg_ff; // R10
      assign receiver_power_down[g] = l_mlo; // R14
      assign channel_mode[4*g +: 4] = mode_ff;
    end
  endgenerate

  always_ff @(negedge tx_line_clock or negedge rstn) begin
    if (!rstn) begin
      lk_host_s1_ff <= 8'h00;
      lk_host_s2_ff <= 8'h00;
      lk_mhi_s1_ff  <= 8'h00;
      lk_mhi_s2_ff  <= 8'h00;
      lk_mlo_s1_ff  <= 8'h00;
      lk_mlo_s2_ff  <= 8'h00;
      lk_edge_s1_ff <= 8'h00;
      lk_edge_s2_ff <= 8'h00;
    end else begin
      lk_host_s1_ff <= {8{host_s2_ff}};
      lk_host_s2_ff <= lk_host_s1_ff;
      lk_mhi_s1_ff  <= {8{mclk_st_ff == LUSIM_MCLK_HIGH}};
      lk_mhi_s2_ff  <= lk_mhi_s1_ff;
      lk_mlo_s1_ff  <= {8{mclk_st_ff == LUSIM_MCLK_LOW}};
      lk_mlo_s2_ff  <= lk_mlo_s1_ff;
      lk_edge_s1_ff <= {8{edge_s2_ff}};
      lk_edge_s2_ff <= lk_edge_s1_ff;
    end
  end

  // Host serial port is outside this block; its edge rule is R18, kept by the serial unit

  AST_SR1_ENTRY: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    g_ch[0].sr1_hit && tx_neg_rail[0] && !lk_mhi_s2_ff[0] |=> g_ch[0].mode_ff == LUSIM_SR1) // R8
    else $error("sub-mode 1 not entered");
  AST_SR1_EXIT: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    !tx_neg_rail[0] |=> g_ch[0].hold_cnt_ff == 5'h00 ##0 g_ch[0].mode_ff != LUSIM_SR1) // R22
    else $error("low rail did not leave sub-mode 1");
  AST_SR2: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    lk_host_s2_ff[1] && single_rail_reg[1] && !recovery_bypass_reg[1] && !lk_mhi_s2_ff[1]
    && !g_ch[1].sr1_hit |=> g_ch[1].mode_ff == LUSIM_SR2) // R9
    else $error("sub-mode 2 not selected");
  AST_RAW_HOST: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    lk_host_s2_ff[2] && recovery_bypass_reg[2] && !single_rail_reg[2] && !g_ch[2].sr1_hit
    |=> g_ch[2].mode_ff == LUSIM_DR_RAW) // R11
    else $error("raw mode not selected");
  AST_MCLK_HIGH: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    lk_mhi_s2_ff[3] |=> g_ch[3].mode_ff == LUSIM_DR_RAW) // R20
    else $error("static high clock did not force raw");
  AST_PWRDN: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    lk_mlo_s2_ff[4] |-> receiver_power_down[4] && !rx_pos_rail[4]) // R14
    else $error("receiver not powered down");
  AST_CODEC: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    g_ch[5].mode_ff == LUSIM_DR_CR |-> !codec_enable[5] && !bipolar_violation_insert[5]) // R21
    else $error("codec active in dual rail");
  AST_TX_SAMPLE: assert property (@(negedge tx_line_clock) disable iff (!rstn)
    1'b1 |=> line_tx_pos[6] == $past(tx_pos_rail[6])) // R19
    else $error("transmit data not sampled");
  AST_RAW_XOR: assert property (@(posedge clk) disable iff (!rstn)
    g_ch[7].raw && !lk_mlo_s2_ff[7] |->
    rx_recovered_clock[7] == (rx_slice_pos[7] ^ rx_slice_neg[7])) // R6
    else $error("raw clock is not rail xor");
  AST_TS: assert property (@(posedge clk) disable iff (!rstn)
    $stable(host_s2_ff) && $stable(template_select_reg) && host_s2_ff
    |=> template_select == $past(template_select_reg)) // R1
    else $error("template select wrong source");

  COV_SR1: cover property (@(negedge tx_line_clock) disable iff (!rstn)
    g_ch[0].mode_ff == LUSIM_SR1);
  COV_SR2: cover property (@(negedge tx_line_clock) disable iff (!rstn)
    g_ch[1].mode_ff == LUSIM_SR2);
  COV_RAW: cover property (@(negedge tx_line_clock) disable iff (!rstn)
    g_ch[2].mode_ff == LUSIM_DR_RAW);
  COV_MLO: cover property (@(posedge clk) disable iff (!rstn)
    mclk_st_ff == LUSIM_MCLK_LOW);
endmodule : lusim_top
`default_nettype wire

// ### lusim_framer_model.sv
// Framer-side model that drives the system transmit rails
`default_nettype none
module lusim_framer_model (
  input  wire logic                 tx_line_clock,
  input  wire logic                 rstn,
  input  wire lusim_pkg::lusim_ch_t hold_neg,
  output lusim_pkg::lusim_ch_t      tx_pos_rail,
  output lusim_pkg::lusim_ch_t      tx_neg_rail
);
  timeunit 1ns;
  timeprecision 1ps;
  import lusim_pkg::*;
  // Launch on the rising edge, so the falling sampling edge sees settled rails
  always @(posedge tx_line_clock or negedge rstn) begin
    if (!rstn) begin
      tx_pos_rail <= 8'h00;
      tx_neg_rail <= 8'h00;
    end else begin
      tx_pos_rail <= lusim_ch_t'($urandom);
      // Negative rail pulses unless the channel is asked to hold it high
      tx_neg_rail <= hold_neg | (~tx_neg_rail & ~hold_neg);
    end
  end
endmodule // lusim_framer_model
`default_nettype wire

// ### tb_lusim_top.sv
// Self-checking bench for the system interface mux
`default_nettype none
module tb_lusim_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lusim_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, tx_line_clock = 1'b0, mclk_in = 1'b0;
  logic        host_mode = 1'b0, edge_polarity_select = 1'b1;
  logic [2:0]  template_select_pins = 3'h0, template_select_reg = 3'h0, template_select;
  lusim_ch_t   recovery_bypass_reg = 8'h00, single_rail_reg = 8'h00, line_code_ami = 8'h00;
  lusim_ch_t   rx_slice_pos = 8'h00, rx_slice_neg = 8'h00, rx_dec_data = 8'h00;
  lusim_ch_t   rx_dec_viol = 8'h00, rx_rec_pos = 8'h00, rx_rec_neg = 8'h00, rx_rec_clk = 8'h00;
  lusim_ch_t   hold_neg = 8'h00, tx_pos_rail, tx_neg_rail, rx_pos_rail, rx_neg_rail;
  lusim_ch_t   rx_recovered_clock, line_tx_pos, line_tx_neg, codec_enable;
  lusim_ch_t   bipolar_violation_insert, receiver_power_down;
  logic [31:0] channel_mode;
  lusim_mclk_e mclk_st = LUSIM_MCLK_RUN;
  int          n_fail = 0;
  int          total_checks = 0;
  always #5 clk = ~clk;
  // Odd start offset keeps the link clock out of phase with clk
  initial begin
    #17;
    forever #40 tx_line_clock = ~tx_line_clock;
  end
  always @(negedge clk) mclk_in <= (mclk_st == LUSIM_MCLK_RUN) ? ~mclk_in
                                                               : (mclk_st == LUSIM_MCLK_HIGH);
  lusim_framer_model lusim_framer_model_inst (.tx_line_clock(tx_line_clock), .rstn(rstn),
    .hold_neg(hold_neg), .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail));
  lusim_top lusim_top_inst (.clk(clk), .rstn(rstn), .tx_line_clock(tx_line_clock),
    .host_mode(host_mode), .template_select_pins(template_select_pins),
    .template_select_reg(template_select_reg), .mclk_in(mclk_in),
    .edge_polarity_select(edge_polarity_select), .recovery_bypass_reg(recovery_bypass_reg),
    .single_rail_reg(single_rail_reg), .line_code_ami(line_code_ami),
    .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail), .rx_slice_pos(rx_slice_pos),
    .rx_slice_neg(rx_slice_neg), .rx_dec_data(rx_dec_data), .rx_dec_viol(rx_dec_viol),
    .rx_rec_pos(rx_rec_pos), .rx_rec_neg(rx_rec_neg), .rx_rec_clk(rx_rec_clk),
    .template_select(template_select), .rx_pos_rail(rx_pos_rail), .rx_neg_rail(rx_neg_rail),
    .rx_recovered_clock(rx_recovered_clock), .line_tx_pos(line_tx_pos),
    .line_tx_neg(line_tx_neg), .codec_enable(codec_enable),
    .bipolar_violation_insert(bipolar_violation_insert),
    .receiver_power_down(receiver_power_down), .channel_mode(channel_mode));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Static high master clock wins, then a held rail, then host bits
  function automatic logic [31:0] exp_mode(input lusim_mclk_e m, input logic host,
                                           input lusim_ch_t held, byp, sr);
    logic [31:0] r;
    for (int c = 0; c < 8; c++) begin
      if (m == LUSIM_MCLK_HIGH) r[4*c +: 4] = LUSIM_DR_RAW;
      else if (held[c]) r[4*c +: 4] = LUSIM_SR1;
      else if (host && sr[c] && !byp[c]) r[4*c +: 4] = LUSIM_SR2;
      else if (host && byp[c] && !sr[c]) r[4*c +: 4] = LUSIM_DR_RAW;
      else r[4*c +: 4] = LUSIM_DR_CR;
    end
    return r;
  endfunction
  task automatic set_host(input logic h, input lusim_ch_t byp, sr);
    @(negedge clk);
    host_mode = h;
    recovery_bypass_reg = byp;
    single_rail_reg = sr;
    line_code_ami = lusim_ch_t'($urandom);
    rx_dec_data = lusim_ch_t'($urandom);
    rx_dec_viol = lusim_ch_t'($urandom);
  endtask
  // Status crosses into the link domain, so allow a minimum wait then poll
  task automatic settle(input logic [31:0] exp);
    repeat (48) @(negedge clk);
    for (int i = 0; i < 400 && channel_mode !== exp; i++) @(negedge clk);
    check("channel_mode", channel_mode, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    n_fail++;
    close_out();
  end
  initial begin
    lusim_ch_t a, b, byp, sr;
    void'($urandom(32'h3DEF8DA6));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    check("reset mode", channel_mode, 32'h11111111);
    check("reset codec", {24'h0, codec_enable}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      host_mode = i[0];
      template_select_pins = 3'($urandom);
      template_select_reg = 3'($urandom);
      repeat (40) @(negedge clk);
      check("template", {29'h0, template_select},
            {29'h0, i[0] ? template_select_reg : template_select_pins});
    end
    $display("test template done");
    set_host(1'b0, 8'hFF, 8'hFF);
    settle(exp_mode(LUSIM_MCLK_RUN, 1'b0, 8'h00, 8'hFF, 8'hFF));
    for (int i = 0; i < 8; i++) begin
      byp = (i == 0) ? 8'hFF : (i == 1) ? 8'h0F : lusim_ch_t'($urandom);
      sr = (i == 0) ? 8'h00 : (i == 1) ? 8'h3C : lusim_ch_t'($urandom);
      set_host(1'b1, byp, sr);
      settle(exp_mode(LUSIM_MCLK_RUN, 1'b1, 8'h00, byp, sr));
      check("codec", {24'h0, codec_enable}, {24'h0, sr & ~byp});
    end
    $display("test host modes done");
    set_host(1'b1, 8'hFF, 8'h00);
    settle(32'h22222222);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      rx_slice_pos = lusim_ch_t'($urandom);
      rx_slice_neg = lusim_ch_t'($urandom);
      edge_polarity_select = i[0];
      // Edge select crosses two domains before it steers the rails
      repeat (30) @(negedge clk);
      a = i[0] ? rx_slice_pos : ~rx_slice_pos;
      b = i[0] ? rx_slice_neg : ~rx_slice_neg;
      check("raw pos", {24'h0, rx_pos_rail}, {24'h0, a});
      check("raw neg", {24'h0, rx_neg_rail}, {24'h0, b});
      check("raw clk", {24'h0, rx_recovered_clock}, {24'h0, rx_slice_pos ^ rx_slice_neg});
      check("raw codec", {24'h0, codec_enable}, 32'h0);
    end
    $display("test raw slicing done");
    set_host(1'b1, 8'h00, 8'h00);
    settle(32'h11111111);
    repeat (8) begin
      @(negedge tx_line_clock);
      #1;
      check("line pos", {24'h0, line_tx_pos}, {24'h0, tx_pos_rail});
      check("line neg", {24'h0, line_tx_neg}, {24'h0, tx_neg_rail});
    end
    for (int e = 1; e >= 0; e--) begin
      @(negedge clk);
      edge_polarity_select = e[0];
      rx_rec_clk = e[0] ? 8'h00 : 8'hFF;
      a = lusim_ch_t'($urandom);
      b = lusim_ch_t'($urandom);
      rx_rec_pos = a;
      rx_rec_neg = b;
      repeat (30) @(negedge clk);
      rx_rec_clk = ~rx_rec_clk;
      repeat (8) @(negedge clk);
      check("rx pos", {24'h0, rx_pos_rail}, {24'h0, a});
      check("rx clk", {24'h0, rx_recovered_clock}, {24'h0, rx_rec_clk});
      rx_rec_pos = ~a;
      rx_rec_neg = ~b;
      rx_rec_clk = ~rx_rec_clk;
      repeat (8) @(negedge clk);
      check("rx pos held", {24'h0, rx_pos_rail}, {24'h0, a});
      check("rx neg held", {24'h0, rx_neg_rail}, {24'h0, b});
    end
    $display("test recovered path done");
    set_host(1'b0, 8'h00, 8'h00);
    hold_neg = 8'h29;
    repeat (15) @(negedge tx_line_clock);
    check("early hold", channel_mode, 32'h11111111);
    settle(exp_mode(LUSIM_MCLK_RUN, 1'b0, 8'h29, 8'h00, 8'h00));
    check("sr1 codec", {24'h0, codec_enable}, 32'h29);
    hold_neg = 8'h00;
    settle(32'h11111111);
    $display("test single rail done");
    set_host(1'b1, 8'h00, 8'h5A);
    mclk_st = LUSIM_MCLK_HIGH;
    settle(32'h22222222);
    mclk_st = LUSIM_MCLK_LOW;
    repeat (60) @(negedge clk);
    check("power down", {24'h0, receiver_power_down}, 32'hFF);
    check("blank rx", {24'h0, rx_pos_rail}, 32'h0);
    mclk_st = LUSIM_MCLK_RUN;
    settle(exp_mode(LUSIM_MCLK_RUN, 1'b1, 8'h00, 8'h00, 8'h5A));
    $display("test master clock done");
    close_out();
  end
endmodule // tb_lusim_top
`default_nettype wire
